// ==== rtl/mbx_defs.svh ====
// Constants for the multiplexed bus and parallel port block.
// Assumes inclusion by bare name from the rtl directory.
`ifndef MBX_DEFS_SVH
`define MBX_DEFS_SVH

// ----------------------------------------------------------------------
// Address space
// ----------------------------------------------------------------------
`define MBX_ADDR_W      13
`define MBX_INT_LIMIT   13'h0080
`define MBX_RAM_BASE    13'h0010
`define MBX_RAM_WORDS   112

// ----------------------------------------------------------------------
// Internal I/O locations (low seven address bits)
// ----------------------------------------------------------------------
`define MBX_LOC_PA_DAT  7'h00
`define MBX_LOC_PB_DAT  7'h01
`define MBX_LOC_PA_DIR  7'h04
`define MBX_LOC_PB_DIR  7'h05
`define MBX_LOC_TMR_LO  7'h08
`define MBX_LOC_TMR_HI  7'h0f

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MBX_DIR_RST     8'h00
`define MBX_BYTE_ZERO   8'h00

`endif

// ==== rtl/mbx_pkg.sv ====
// Types shared by the multiplexed bus block.
// Assumes nothing beyond a SystemVerilog compiler.
package mbx_pkg;

  // ----------------------------------------------------------------------
  // Bus cycle phases, five per cycle plus standby
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_HOLD,
    PH_DATA,
    PH_DLAT,
    PH_END
  } mbx_phase_t;

endpackage

// ==== rtl/mbx_bus.sv ====
// Multiplexed address/data bus interface with internal space decode and
// two 8-bit bidirectional ports with direction registers.
// Assumes clk is the oscillator input and the core drives one request
// per bus cycle; the timer lives outside and is reached via tmr_* ports.
//
// Functional notes
// - addr_strobe pulses each bus cycle, osc/5, except in standby.
// - data_strobe appears on every read or write, internal too.
// - data_strobe runs at osc/5 outside standby; some are dummy reads.
// - Read/write line low for writes, high for reads, next data strobe.
// - Read/write line rests high when no write is in progress.
// - Shared lines: address at addr_strobe, data at data_strobe.
// - Shared lines driven on writes, sampled on reads in data phase.
// - Bus cycle rate is the oscillator input divided by five.
// - Read data is latched at the falling edge of data_strobe.
// - fetch_indicator high on opcode fetch, low in interrupt sequences.
// - Port line output when direction bit 1, input when 0; readable.
// - Reading an output bit returns the output latch value.
// - Reading an input bit returns the live pin level.
// - Port writes always update latch; pin driven only where bit is 1.
// - Reset clears all direction bits, making every line an input.
// - Reset leaves the port output latches untouched.
// - Decoded address space is 8192 bytes.
// - Lowest 128 addresses internal, with 112 RAM bytes; rest external.
// - Internal writes are repeated on the external bus.
// - Internal reads run on the bus but take internal data only.
`timescale 1ns/1ps
`include "mbx_defs.svh"

module mbx_bus #(
  parameter int ADDR_W   = `MBX_ADDR_W,
  parameter int RAM_WORDS = `MBX_RAM_WORDS
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Core request side
  input  wire logic              standby,
  input  wire logic              core_valid,
  output logic                   core_ready,
  input  wire logic [ADDR_W-1:0] core_addr,
  input  wire logic              core_we,
  input  wire logic [7:0]        core_wdata,
  input  wire logic              core_fetch,
  input  wire logic              core_irq_seq,
  output logic                   core_done,
  output logic [7:0]             core_rdata,
  // Timer register window
  output logic                   tmr_wr,
  output logic [2:0]             tmr_addr,
  output logic [7:0]             tmr_wdata,
  input  wire logic [7:0]        tmr_rdata,
  // External bus
  output logic                   addr_strobe,
  output logic                   data_strobe,
  output logic                   rd_wr_n,
  output logic [4:0]             high_addr_out,
  output logic                   fetch_indicator,
  input  wire logic [7:0]        shared_addr_data_in,
  output logic [7:0]             shared_addr_data_out,
  output logic                   shared_addr_data_oe,
  // Parallel ports
  input  wire logic [7:0]        port_a_lines_in,
  output logic [7:0]             port_a_lines_out,
  output logic [7:0]             port_a_lines_oe,
  input  wire logic [7:0]        port_b_lines_in,
  output logic [7:0]             port_b_lines_out,
  output logic [7:0]             port_b_lines_oe
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Output bits give the latch, input bits the live pin
  function automatic logic [7:0] port_view(input logic [7:0] dir,
                                           input logic [7:0] lat,
                                           input logic [7:0] pin);
    port_view = (dir & lat) | (~dir & pin);
  endfunction

  // Below the internal limit the data is served on chip, though the cycle still runs on the bus
  function automatic logic is_internal(input logic [ADDR_W-1:0] a);
    is_internal = (a < ADDR_W'(`MBX_INT_LIMIT));
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mbx_pkg::mbx_phase_t ph_r;
  mbx_pkg::mbx_phase_t ph_nxt;
  logic [ADDR_W-1:0]   addr_r;
  logic                we_r;
  logic [7:0]          wdata_r;
  logic                fetch_r;
  logic                real_r;
  logic [7:0]          dir_a_r;
  logic [7:0]          dir_b_r;
  logic [7:0]          lat_a_r;
  logic [7:0]          lat_b_r;
  logic [7:0]          ram_r [0:RAM_WORDS-1];
  logic [7:0]          int_rdata;
  logic [6:0]          loc;
  logic                in_ram;
  logic                in_tmr;
  logic                commit;
  logic                taken;

  assign loc    = addr_r[6:0];
  assign in_ram = is_internal(addr_r) &&
                  (addr_r >= ADDR_W'(`MBX_RAM_BASE));
  assign in_tmr = is_internal(addr_r) && (loc >= `MBX_LOC_TMR_LO) &&
                  (loc <= `MBX_LOC_TMR_HI);
  // Data strobe falls on the edge leaving the latch phase
  assign commit = (ph_r == mbx_pkg::PH_DLAT);

  // ----------------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------------
  // A new cycle may only start from standby or the last phase
  assign core_ready = ((ph_r == mbx_pkg::PH_END) ||
                       (ph_r == mbx_pkg::PH_IDLE)) && !standby;
  assign taken      = core_ready && core_valid;

  // Five phases per cycle divide the oscillator by five
  always_comb begin
    case (ph_r)
      mbx_pkg::PH_ADDR: ph_nxt = mbx_pkg::PH_HOLD;
      mbx_pkg::PH_HOLD: ph_nxt = mbx_pkg::PH_DATA;
      mbx_pkg::PH_DATA: ph_nxt = mbx_pkg::PH_DLAT;
      mbx_pkg::PH_DLAT: ph_nxt = mbx_pkg::PH_END;
      default: begin
        // Standby holds both strobes still
        ph_nxt = standby ? mbx_pkg::PH_IDLE : mbx_pkg::PH_ADDR;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph_r <= mbx_pkg::PH_IDLE;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------------
  // Without a request the old address is read again as a dummy cycle;
  // keeps the strobes running at the cost of a wasted external read
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r  <= '0;
      we_r    <= 1'b0;
      wdata_r <= `MBX_BYTE_ZERO;
      fetch_r <= 1'b0;
      real_r  <= 1'b0;
    end else if (taken) begin
      addr_r  <= core_addr;
      we_r    <= core_we;
      wdata_r <= core_wdata;
      fetch_r <= core_fetch && !core_we;
      real_r  <= 1'b1;
    end else if (ph_nxt == mbx_pkg::PH_ADDR) begin
      we_r    <= 1'b0;
      fetch_r <= 1'b0;
      real_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Strobes and direction line
  // ----------------------------------------------------------------------
  // Registered from the next phase so the pins change with the phase
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_strobe <= 1'b0;
      data_strobe <= 1'b0;
    end else begin
      addr_strobe <= (ph_nxt == mbx_pkg::PH_ADDR);
      data_strobe <= (ph_nxt == mbx_pkg::PH_DATA) ||
                     (ph_nxt == mbx_pkg::PH_DLAT);
    end
  end

  // Direction follows the captured request; high outside writes
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_wr_n <= 1'b1;
    end else if (taken) begin
      rd_wr_n <= !core_we;
    end else if (ph_nxt == mbx_pkg::PH_ADDR ||
                 ph_nxt == mbx_pkg::PH_IDLE) begin
      rd_wr_n <= 1'b1;
    end
  end

  // Interrupt sequences force the indicator low
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_indicator <= 1'b0;
    end else if (core_irq_seq) begin
      fetch_indicator <= 1'b0;
    end else if (taken) begin
      fetch_indicator <= core_fetch && !core_we;
    end else if (ph_nxt == mbx_pkg::PH_ADDR ||
                 ph_nxt == mbx_pkg::PH_IDLE) begin
      fetch_indicator <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Address and data lines
  // ----------------------------------------------------------------------
  // High address stays for the whole cycle; low byte in the address and hold
  // phases, write data from the data phase to the end phase, released for reads
  always_ff @(posedge clk) begin
    if (rst) begin
      high_addr_out        <= '0;
      shared_addr_data_out <= `MBX_BYTE_ZERO;
      shared_addr_data_oe  <= 1'b0;
    end else begin
      if (taken) begin
        high_addr_out <= core_addr[ADDR_W-1:8];
      end
      case (ph_nxt)
        mbx_pkg::PH_ADDR: begin
          shared_addr_data_out <= taken ? core_addr[7:0] : addr_r[7:0];
          shared_addr_data_oe  <= 1'b1;
        end
        mbx_pkg::PH_HOLD: begin
          shared_addr_data_oe  <= 1'b1;
        end
        mbx_pkg::PH_DATA, mbx_pkg::PH_DLAT, mbx_pkg::PH_END: begin
          // Internal writes are also shown on the bus
          shared_addr_data_out <= wdata_r;
          shared_addr_data_oe  <= we_r;
        end
        default: begin
          shared_addr_data_oe  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Internal read mux
  // ----------------------------------------------------------------------
  always_comb begin
    int_rdata = `MBX_BYTE_ZERO;
    if (in_ram) begin
      int_rdata = ram_r[7'(addr_r - ADDR_W'(`MBX_RAM_BASE))];
    end else if (in_tmr) begin
      int_rdata = tmr_rdata;
    end else if (loc == `MBX_LOC_PA_DAT) begin
      int_rdata = port_view(dir_a_r, lat_a_r, port_a_lines_in);
    end else if (loc == `MBX_LOC_PB_DAT) begin
      int_rdata = port_view(dir_b_r, lat_b_r, port_b_lines_in);
    end else if (loc == `MBX_LOC_PA_DIR) begin
      int_rdata = dir_a_r;
    end else if (loc == `MBX_LOC_PB_DIR) begin
      int_rdata = dir_b_r;
    end
  end

  // ----------------------------------------------------------------------
  // Read data return
  // ----------------------------------------------------------------------
  // Sampled as data strobe falls; internal reads ignore the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      core_rdata <= `MBX_BYTE_ZERO;
      core_done  <= 1'b0;
    end else begin
      core_done <= commit && real_r;
      if (commit && real_r && !we_r) begin
        core_rdata <= is_internal(addr_r) ? int_rdata
                                          : shared_addr_data_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Internal writes
  // ----------------------------------------------------------------------
  // RAM has no reset; contents are whatever software left there
  always_ff @(posedge clk) begin
    if (commit && real_r && we_r && in_ram) begin
      ram_r[7'(addr_r - ADDR_W'(`MBX_RAM_BASE))] <= wdata_r;
    end
  end

  // Timer window write strobe, one cycle at data strobe fall
  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_wr    <= 1'b0;
      tmr_addr  <= '0;
      tmr_wdata <= `MBX_BYTE_ZERO;
    end else begin
      tmr_wr <= commit && real_r && we_r && in_tmr;
      if (commit && real_r && we_r && in_tmr) begin
        tmr_addr  <= loc[2:0];
        tmr_wdata <= wdata_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Port direction registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dir_a_r <= `MBX_DIR_RST;
      dir_b_r <= `MBX_DIR_RST;
    end else if (commit && real_r && we_r && is_internal(addr_r)) begin
      if (loc == `MBX_LOC_PA_DIR) begin
        dir_a_r <= wdata_r;
      end else if (loc == `MBX_LOC_PB_DIR) begin
        dir_b_r <= wdata_r;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Port output latches
  // ----------------------------------------------------------------------
  // Deliberately outside reset so a reset keeps the last output values
  always_ff @(posedge clk) begin
    if (commit && real_r && we_r && is_internal(addr_r)) begin
      if (loc == `MBX_LOC_PA_DAT) begin
        lat_a_r <= wdata_r;
      end else if (loc == `MBX_LOC_PB_DAT) begin
        lat_b_r <= wdata_r;
      end
    end
  end

  // Pins carry the latch, enabled bit by bit from the direction
  assign port_a_lines_out = lat_a_r;
  assign port_a_lines_oe  = dir_a_r;
  assign port_b_lines_out = lat_b_r;
  assign port_b_lines_oe  = dir_b_r;

endmodule

// ==== dv/mbx_bus_sva.sv ====
// Checker for mbx_bus: bus cycle shape, data phases, port directions.
// Assumes it is bound into every mbx_bus instance by the bind below.
`timescale 1ns/1ps
module mbx_bus_sva #(
  parameter int ADDR_W = 13
) (
  // Clock, reset and core side
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              standby,
  input wire logic              core_valid,
  input wire logic              core_ready,
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic              core_we,
  input wire logic [7:0]        core_wdata,
  input wire logic              core_irq_seq,
  input wire logic              core_done,
  input wire logic [7:0]        core_rdata,
  // External bus and ports
  input wire logic              addr_strobe,
  input wire logic              data_strobe,
  input wire logic              rd_wr_n,
  input wire logic [4:0]        high_addr_out,
  input wire logic              fetch_indicator,
  input wire logic [7:0]        shared_addr_data_in,
  input wire logic [7:0]        shared_addr_data_out,
  input wire logic              shared_addr_data_oe,
  input wire logic [7:0]        port_a_lines_oe,
  input wire logic [7:0]        port_b_lines_oe
);
  logic              take;
  logic              we_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        wd_r;
  logic [7:0]        bus_r;
  assign take = core_valid && core_ready;
  // Taken request, held through its bus cycle
  always_ff @(posedge clk) begin
    if (take) begin
      addr_r <= core_addr;
      we_r   <= core_we;
      wd_r   <= core_wdata;
    end
  end
  // Bus level at the last edge of the data strobe
  always_ff @(posedge clk) begin
    if (data_strobe) begin
      bus_r <= shared_addr_data_in;
    end
  end
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_addr;
    addr_strobe && !data_strobe ##1 !addr_strobe && !data_strobe;
  endsequence
  sequence s_data;
    data_strobe [*2] ##1 !data_strobe;
  endsequence
  AST_CYCLE: assert property (s_addr |=> s_data)
    else $error("data strobe misplaced after address strobe");
  AST_AS: assert property (addr_strobe |=>
    !addr_strobe [*4] ##1 (addr_strobe || $past(standby)))
    else $error("address strobe period is not five clocks");
  AST_RW: assert property (take && core_we |=> !rd_wr_n [*5])
    else $error("write cycle without low read/write line");
  AST_ADDR: assert property (take |=> addr_strobe &&
    shared_addr_data_oe && shared_addr_data_out == addr_r[7:0] &&
    high_addr_out == addr_r[ADDR_W-1:8])
    else $error("address phase shows wrong address");
  AST_WDATA: assert property (take && core_we |=> ##2
    (shared_addr_data_oe && shared_addr_data_out == wd_r) [*2])
    else $error("write data not driven under data strobe");
  AST_REXT: assert property (core_done && !we_r &&
    addr_r[ADDR_W-1:7] != '0 |-> core_rdata == bus_r)
    else $error("external read data not taken at strobe fall");
  AST_IRQ: assert property (core_irq_seq |=> !fetch_indicator)
    else $error("fetch indicator high in interrupt sequence");
  AST_DIR: assert property (disable iff (1'b0) rst |=>
    port_a_lines_oe == 8'h00 && port_b_lines_oe == 8'h00)
    else $error("port lines not inputs after reset");
endmodule

bind mbx_bus mbx_bus_sva #(.ADDR_W(ADDR_W)) chk_u (.*);

// ==== dv/mbx_ext_mem.sv ====
// Far side of the bus: low address latch and 8K bytes of memory.
// Assumes registered strobes and one driver of the lines per phase.
`timescale 1ns/1ps
module mbx_ext_mem (
  // Strobes and direction
  input  wire logic       addr_strobe,
  input  wire logic       data_strobe,
  input  wire logic       rd_wr_n,
  // Address and data lines
  input  wire logic [4:0] high_addr_out,
  input  wire logic [7:0] shared_addr_data_out,
  input  wire logic       shared_addr_data_oe,
  output logic      [7:0] shared_addr_data_in
);
  logic [7:0] mem [0:8191];
  logic [7:0] lat_lo;
  logic [7:0] last;
  logic [7:0] rdv;
  logic       drv;
  // Low address byte captured as the address strobe falls
  always @(negedge addr_strobe) lat_lo = shared_addr_data_out;
  // Writes land as the data strobe falls, data still driven then
  always @(negedge data_strobe) begin
    if (!rd_wr_n) mem[{high_addr_out, lat_lo}] = shared_addr_data_out;
    last = rdv;
  end
  // Drive only in a read data phase; released lines show the inverse
  assign rdv = mem[{high_addr_out, lat_lo}];
  assign drv = data_strobe && rd_wr_n && !shared_addr_data_oe;
  assign shared_addr_data_in = shared_addr_data_oe ? shared_addr_data_out :
                               drv ? rdv : ~last;
endmodule

// ==== dv/tb_muxed_bus_and_io_ports.sv ====
// Bench for mbx_bus: bus cycles, internal map, ports and standby.
// Assumes mbx_ext_mem on the far side and the checker bound to dut_u.
`timescale 1ns/1ps
module tb_muxed_bus_and_io_ports;
  logic        clk, rst, standby, core_valid, core_ready, core_we;
  logic        core_fetch, core_irq_seq, core_done, tmr_wr, rd_wr_n;
  logic        addr_strobe, data_strobe, fetch_indicator;
  logic        shared_addr_data_oe;
  logic [12:0] core_addr;
  logic [7:0]  core_wdata, core_rdata, tmr_wdata, tmr_rdata, pin_ext, rd;
  logic [7:0]  shared_addr_data_in, shared_addr_data_out;
  logic [7:0]  port_a_lines_in, port_a_lines_out, port_a_lines_oe;
  logic [7:0]  port_b_lines_in, port_b_lines_out, port_b_lines_oe;
  logic [4:0]  high_addr_out;
  logic [2:0]  tmr_addr;
  int          fail_count, cmp_count;

  // Pin level: port drives where enabled, the board elsewhere
  assign port_a_lines_in = (port_a_lines_out & port_a_lines_oe) |
                           (pin_ext & ~port_a_lines_oe);
  assign port_b_lines_in = (port_b_lines_out & port_b_lines_oe) |
                           (pin_ext & ~port_b_lines_oe);
  mbx_bus     dut_u (.*);
  mbx_ext_mem ext_u (.*);

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compare and count
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One core request, entered at a falling edge; bounded waits
  task automatic op(logic [12:0] a, logic we, logic [7:0] wd, logic f);
    int n;
    core_addr = a;
    core_we = we;
    core_wdata = wd;
    core_fetch = f;
    core_valid = 1'b1;
    for (n = 0; n < 10 && core_ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    core_valid = 1'b0;
    for (n = 0; n < 10 && core_done !== 1'b1; n++) @(negedge clk);
    chk("done", {7'h00, core_done}, 8'h01);
    rd = core_rdata;
  endtask

  // Reset held five cycles, released at a falling edge
  task automatic do_reset;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
  endtask

  // External writes and reads, lowest external address too
  task automatic t_ext;
    ext_u.mem[13'h0080] = 8'h3c;
    op(13'h1a5, 1'b1, 8'h5c, 1'b0);
    chk("mem 1a5", ext_u.mem[13'h1a5], 8'h5c);
    op(13'h0080, 1'b0, 8'h00, 1'b0);
    chk("rd 080", rd, 8'h3c);
    op(13'h1a5, 1'b0, 8'h00, 1'b0);
    chk("rd 1a5", rd, 8'h5c);
  endtask

  // Internal RAM: writes mirrored, reads ignore the bus
  task automatic t_int;
    op(13'h007f, 1'b1, 8'ha5, 1'b0);
    chk("mirror", ext_u.mem[13'h007f], 8'ha5);
    ext_u.mem[13'h007f] = 8'h5a;
    op(13'h0010, 1'b1, 8'h11, 1'b0);
    op(13'h007f, 1'b0, 8'h00, 1'b0);
    chk("ram 07f", rd, 8'ha5);
    op(13'h0010, 1'b0, 8'h00, 1'b0);
    chk("ram 010", rd, 8'h11);
  endtask

  // Ports: mixed directions on A, all inputs on B, then a reset
  task automatic t_port;
    logic [7:0] dv;
    for (int p = 0; p < 2; p++) begin
      dv = p ? 8'h00 : 8'hf0;
      op(13'(4 + p), 1'b1, dv, 1'b0);
      op(13'(p), 1'b1, 8'h3c, 1'b0);
      op(13'(4 + p), 1'b0, 8'h00, 1'b0);
      chk("dir", rd, dv);
      op(13'(p), 1'b0, 8'h00, 1'b0);
      chk("port", rd, (8'h3c & dv) | (pin_ext & ~dv));
    end
    chk("a oe", port_a_lines_oe, 8'hf0);
    chk("a out", port_a_lines_out, 8'h3c);
    chk("b oe", port_b_lines_oe, 8'h00);
    chk("b out", port_b_lines_out, 8'h3c);
    do_reset;
    chk("a oe rst", port_a_lines_oe, 8'h00);
    chk("a out rst", port_a_lines_out, 8'h3c);
  endtask

  // Timer window: write strobe with offset and data, read returns timer
  task automatic t_tmr;
    op(13'h000a, 1'b1, 8'h6b, 1'b0);
    chk("tmr wr", {7'h00, tmr_wr}, 8'h01);
    chk("tmr addr", {5'h00, tmr_addr}, 8'h02);
    chk("tmr data", tmr_wdata, 8'h6b);
    op(13'h000d, 1'b0, 8'h00, 1'b0);
    chk("tmr rd", rd, 8'hc3);
    chk("tmr wr rd", {7'h00, tmr_wr}, 8'h00);
    op(13'h0002, 1'b0, 8'h00, 1'b0);
    chk("spare rd", rd, 8'h00);
  endtask

  // Fetch indicator in a fetch, and forced low by an interrupt;
  // the fetched byte is preset so no unknown reaches the checker
  task automatic t_fetch;
    ext_u.mem[13'h0200] = 8'h9d;
    op(13'h0200, 1'b0, 8'h00, 1'b1);
    chk("fetch", {7'h00, fetch_indicator}, 8'h01);
    chk("fetch rd", rd, 8'h9d);
    core_irq_seq = 1'b1;
    op(13'h0200, 1'b0, 8'h00, 1'b1);
    chk("irq fetch", {7'h00, fetch_indicator}, 8'h00);
    core_irq_seq = 1'b0;
  endtask

  // Count falling edges with each strobe high over a span of falling edges
  task automatic cnt(int n, logic [7:0] ea, logic [7:0] ed);
    logic [7:0] na;
    logic [7:0] nd;
    na = 8'h00;
    nd = 8'h00;
    repeat (n) begin
      @(negedge clk);
      na += addr_strobe;
      nd += data_strobe;
    end
    chk("as count", na, ea);
    chk("ds count", nd, ed);
  endtask

  // Standby stops the strobes; free running cycles resume after
  task automatic t_strobe;
    standby = 1'b1;
    repeat (6) @(negedge clk);
    cnt(10, 8'h00, 8'h00);
    standby = 1'b0;
    cnt(25, 8'h05, 8'h0a);
    chk("rw rest", {7'h00, rd_wr_n}, 8'h01);
  endtask

  // Print counts and the verdict, then stop
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    {standby, core_valid, core_we, core_fetch, core_irq_seq} = 5'h00;
    core_addr = 13'h0000;
    core_wdata = 8'h00;
    tmr_rdata = 8'hc3;
    pin_ext = 8'h96;
    do_reset;
    chk("dir a", port_a_lines_oe, 8'h00);
    t_ext;
    t_int;
    t_tmr;
    t_port;
    t_fetch;
    t_strobe;
    print_verdict;
  end

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    print_verdict;
  end
endmodule
